// ---- hw/adc_sel_defs.vh ----
// Register offsets, field positions, reset values and timing constants for the converter input selection block
`ifndef ADC_SEL_DEFS_VH
`define ADC_SEL_DEFS_VH

// Register byte offsets on the 32-bit register bus
`define OFS_INPUT_MUX_SELECT 12'h000
`define OFS_PIN_CFG_LOW 12'h004
`define OFS_PIN_CFG_HIGH 12'h008
`define OFS_SCAN_MASK 12'h00C
`define OFS_CONV_CTRL 12'h010
`define OFS_SAMPLE_STATUS 12'h014

// Writable bit masks per register
`define MASK_INPUT_MUX_SELECT 16'h9F9F
`define MASK_PIN_CFG_HIGH 16'h0003
`define MASK_CONV_CTRL 16'h03FF

// Field positions inside the input select register
`define NEG_B_BIT 15
`define POS_B_MSB 12
`define POS_B_LSB 8
`define NEG_A_BIT 7
`define POS_A_MSB 4
`define POS_A_LSB 0

// Field positions inside the conversion control register
`define DIV_MSB 7
`define DIV_LSB 0
`define SCAN_EN_BIT 8
`define ALT_MODE_BIT 9

// Field positions inside the high pin configuration register
`define BG_DIS_BIT 1
`define HALF_BG_DIS_BIT 0

// Positive input codes
`define CODE_HALF_BG 5'h10
`define CODE_FULL_BG 5'h11

// Reset value of every implemented register bit
`define REG_RESET 16'h0000

// Instruction cycle is two system clocks
`define TCY_CLOCKS 2

`endif

// ---- hw/adc_input_select.v ----
// Input selection, pin configuration, scan sequencing and conversion clock for the converter
//
// Implementation choices: the placing of the registers and the APB register port.

`include "adc_sel_defs.vh"

module adc_input_select (
    // System clock and reset
    input wire CLK_SYS,
    input wire RST_N,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // Sample handshake from the conversion engine
    input wire SAMPLE_START,
    input wire SEQ_RESTART,
    // Sample-and-hold selection
    output reg [4:0] POS_INPUT_SEL,
    output reg NEG_INPUT_IS_PIN_ONE,
    output reg SAMPLE_USES_SETTING_B,
    // Pin mode
    output reg [15:0] PIN_DIGITAL_MODE,
    output reg [15:0] PIN_ANALOG_SAMPLE_EN,
    // Conversion clock enable
    output reg CONV_CLOCK_TICK
);

    // Software visible registers
    // All are 16 bits wide and sit in the low half of a bus word
    // Unimplemented bits are never stored, so reads need no masking
    reg [15:0] input_mux_select_r; // Both multiplexer settings
    reg [15:0] pin_analog_config_low_r; // Digital mode per pin
    reg [15:0] pin_analog_config_high_r; // Bandgap scan disables
    reg [15:0] scan_channel_mask_r; // Scan include per pin
    reg [15:0] conv_ctrl_r; // Divider, scan enable, alternate mode

    // Sequencing state
    // Changed only by a sample start or a restart, never by a bus write
    // Scan position: 0-15 pins, 16 half bandgap, 17 bandgap
    reg use_b_r; // Next sample uses setting B
    reg [4:0] scan_pos_r; // Last scanned channel, 0-17; takes the fixed field value, up to 31, after an empty scan list
    reg scan_first_r; // No channel scanned yet in sequence

    // Conversion clock divider
    // Two system clocks form one instruction cycle
    // The count runs in whole instruction cycles
    reg [7:0] period_cnt_r; // Counts instruction cycles
    reg tcy_phase_r; // Instruction cycle is two clocks

    // Field views
    // Plain wires into the stored registers, no extra state
    // Divider, scan enable and alternate mode share one control word
    wire [7:0] conv_clock_divider = conv_ctrl_r[`DIV_MSB:`DIV_LSB];
    wire scan_enable = conv_ctrl_r[`SCAN_EN_BIT];
    wire alternate_setting_mode = conv_ctrl_r[`ALT_MODE_BIT];
    wire neg_select_setting_b = input_mux_select_r[`NEG_B_BIT];
    wire [4:0] pos_select_setting_b = input_mux_select_r[`POS_B_MSB:`POS_B_LSB];
    wire neg_select_setting_a = input_mux_select_r[`NEG_A_BIT];
    wire [4:0] pos_select_setting_a = input_mux_select_r[`POS_A_MSB:`POS_A_LSB];

    // APB access decode
    // A write lands only in the access cycle, once ready is already high
    // Ready comes from a flip-flop, so no path runs from select to ready
    // Status offset decodes as a hit but accepts no data
    wire apb_write = PSEL && PENABLE && PWRITE && PREADY;
    wire apb_setup = PSEL && !PENABLE;
    wire addr_hit = (PADDR == `OFS_INPUT_MUX_SELECT) || (PADDR == `OFS_PIN_CFG_LOW) ||
                    (PADDR == `OFS_PIN_CFG_HIGH) || (PADDR == `OFS_SCAN_MASK) ||
                    (PADDR == `OFS_CONV_CTRL) || (PADDR == `OFS_SAMPLE_STATUS);

    // Scan eligibility over 18 positions: 16 pins, half bandgap, bandgap
    // Pins need their mask bit set to take part
    // Internal channels take part unless their disable bit is set
    // So both internal channels are eligible straight after reset
    wire [17:0] scan_ok;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_scan
            // Pin must be selected by the mask
            assign scan_ok[gi] = scan_channel_mask_r[gi];
        end
    endgenerate
    // Internal channels sit above the pins
    assign scan_ok[16] = !pin_analog_config_high_r[`HALF_BG_DIS_BIT];
    assign scan_ok[17] = !pin_analog_config_high_r[`BG_DIS_BIT];

    // Next scan channel: lowest eligible above current, else lowest overall
    // Pure search over all 18 positions, settled within one clock
    // A priority chain of 18 entries is cheap enough at 50 MHz
    // After a restart the lowest eligible position comes first
    // Used only for setting A samples while scanning
    reg [4:0] scan_next;
    reg scan_found;
    reg [4:0] scan_low;
    reg low_found;
    integer k;
    always @* begin
        // Defaults keep the search free of latches
        scan_next = 5'h00;
        scan_found = 1'b0;
        scan_low = 5'h00;
        low_found = 1'b0;
        for (k = 17; k >= 0; k = k - 1) begin
            // Lowest eligible wins because loop counts downward
            if (scan_ok[k]) begin
                // Track the lowest eligible for the wrap
                scan_low = k[4:0];
                low_found = 1'b1;
                // Candidate above the last scanned position
                if (scan_first_r || (k[4:0] > scan_pos_r)) begin
                    scan_next = k[4:0];
                    scan_found = 1'b1;
                end
            end
        end
        // Wrap to lowest after highest
        if (!scan_found) begin
            scan_next = scan_low;
        end
        // Empty scan list falls back to the fixed field
        if (!low_found) begin
            scan_next = pos_select_setting_a;
        end
    end

    // Scan position code maps to the positive input code
    // Positions and codes agree today; kept apart so a remap is local
    // Positions above 17 pass through unchanged, above the full bandgap code
    function [4:0] scan_code;
        input [4:0] pos;
        begin
            if (pos == 5'h10) begin
                // Half bandgap
                scan_code = `CODE_HALF_BG;
            end else if (pos == 5'h11) begin
                // Full bandgap
                scan_code = `CODE_FULL_BG;
            end else begin
                // Analog pin number
                scan_code = pos;
            end
        end
    endfunction

    // Register writes, masked so unimplemented bits stay zero
    // One register at most changes per access, chosen by the byte address
    // Writes to the status word and to unmapped addresses are dropped
    // Config changes reach the pin outputs one clock later
    // Selection changes reach the sample outputs only at the next start
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            // Power-on state: every implemented bit zero
            input_mux_select_r <= `REG_RESET;
            pin_analog_config_low_r <= `REG_RESET;
            pin_analog_config_high_r <= `REG_RESET;
            scan_channel_mask_r <= `REG_RESET;
            conv_ctrl_r <= `REG_RESET;
        end else if (apb_write) begin
            case (PADDR)
                `OFS_INPUT_MUX_SELECT: begin
                    // Bits 14:13 and 6:5 are masked off
                    input_mux_select_r <= PWDATA[15:0] & `MASK_INPUT_MUX_SELECT;
                end
                `OFS_PIN_CFG_LOW: begin
                    // All sixteen bits are implemented
                    pin_analog_config_low_r <= PWDATA[15:0];
                end
                `OFS_PIN_CFG_HIGH: begin
                    // Only the two internal channel disables exist
                    pin_analog_config_high_r <= PWDATA[15:0] & `MASK_PIN_CFG_HIGH;
                end
                `OFS_SCAN_MASK: begin
                    // One include bit per pin
                    scan_channel_mask_r <= PWDATA[15:0];
                end
                `OFS_CONV_CTRL: begin
                    // Reserved divider values are stored as written, not trapped
                    conv_ctrl_r <= PWDATA[15:0] & `MASK_CONV_CTRL;
                end
                default: begin
                    // Status and unmapped: no effect
                end
            endcase
        end
    end

    // APB answer: no wait state, data registered at the end of setup
    // Read data is captured at the setup edge, so a write that landed
    // at the previous access edge is already visible
    // Error flag marks unmapped addresses and lasts only with ready
    // Read data holds until the next setup
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            // Idle bus: no answer pending
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else if (apb_setup) begin
            // Answer every setup in the next cycle
            PREADY <= 1'b1;
            PSLVERR <= !addr_hit;
            case (PADDR)
                `OFS_INPUT_MUX_SELECT: begin
                    PRDATA <= {16'h0000, input_mux_select_r};
                end
                `OFS_PIN_CFG_LOW: begin
                    PRDATA <= {16'h0000, pin_analog_config_low_r};
                end
                `OFS_PIN_CFG_HIGH: begin
                    PRDATA <= {16'h0000, pin_analog_config_high_r};
                end
                `OFS_SCAN_MASK: begin
                    PRDATA <= {16'h0000, scan_channel_mask_r};
                end
                `OFS_CONV_CTRL: begin
                    PRDATA <= {16'h0000, conv_ctrl_r};
                end
                `OFS_SAMPLE_STATUS: begin
                    // Live sample selection
                    PRDATA <= {16'h0000, 8'h00, SAMPLE_USES_SETTING_B, NEG_INPUT_IS_PIN_ONE, 1'b0, POS_INPUT_SEL};
                end
                default: begin
                    // Unmapped reads return zero
                    PRDATA <= 32'h00000000;
                end
            endcase
        end else begin
            // Ready only in the single access cycle
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // Sample selection latched at sample start only
    // Restart wins over a start in the same cycle
    // Restart leaves the outputs alone; they still describe the last sample
    // With alternate mode off every sample uses setting A
    // Setting B samples never move the scan position
    // Limitation: an empty scan list falls back to the fixed field
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            // First sample after reset uses setting A
            POS_INPUT_SEL <= 5'h00;
            NEG_INPUT_IS_PIN_ONE <= 1'b0;
            SAMPLE_USES_SETTING_B <= 1'b0;
            use_b_r <= 1'b0;
            scan_pos_r <= 5'h00;
            scan_first_r <= 1'b1;
        end else if (SEQ_RESTART) begin
            // New sequence begins with setting A and the lowest channel
            use_b_r <= 1'b0;
            scan_first_r <= 1'b1;
        end else if (SAMPLE_START) begin
            // Held until the next start, so writes never disturb a running sample
            if (alternate_setting_mode && use_b_r) begin
                // Setting B: both inputs from the B fields
                POS_INPUT_SEL <= pos_select_setting_b;
                NEG_INPUT_IS_PIN_ONE <= neg_select_setting_b;
                SAMPLE_USES_SETTING_B <= 1'b1;
            end else begin
                if (scan_enable) begin
                    // Scan supplies the positive input, negative stays fixed
                    POS_INPUT_SEL <= scan_code(scan_next);
                    scan_pos_r <= scan_next;
                    scan_first_r <= 1'b0;
                end else begin
                    // Fixed positive field of setting A
                    POS_INPUT_SEL <= pos_select_setting_a;
                end
                NEG_INPUT_IS_PIN_ONE <= neg_select_setting_a;
                SAMPLE_USES_SETTING_B <= 1'b0;
            end
            // Toggle only while alternating
            use_b_r <= alternate_setting_mode && !use_b_r;
        end
    end

    // Pin mode outputs follow the low configuration register
    // One clock of delay keeps every output straight from a flip-flop
    // Reset shows every pin analog, matching the cleared configuration
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            PIN_DIGITAL_MODE <= `REG_RESET;
            PIN_ANALOG_SAMPLE_EN <= ~`REG_RESET;
        end else begin
            // Copy and its inverse, both registered
            PIN_DIGITAL_MODE <= pin_analog_config_low_r;
            PIN_ANALOG_SAMPLE_EN <= ~pin_analog_config_low_r;
        end
    end

    // Conversion clock: one tick every TCY_CLOCKS*(divider+1) system clocks
    // Divider is read live; a smaller value ends the running period early
    // because the count compares with greater-or-equal
    // Reserved divider values are honoured, giving periods up to 512 clocks
    // Tick is a one-cycle enable, not a clock; nothing here runs on it
    always @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            // Count and phase start at zero
            tcy_phase_r <= 1'b0;
            period_cnt_r <= 8'h00;
            CONV_CLOCK_TICK <= 1'b0;
        end else begin
            // Default low, raised for one cycle below
            CONV_CLOCK_TICK <= 1'b0;
            tcy_phase_r <= !tcy_phase_r;
            // Count on the last clock of each instruction cycle
            if (tcy_phase_r) begin
                if (period_cnt_r >= conv_clock_divider) begin
                    // Period complete: restart the count and tick
                    period_cnt_r <= 8'h00;
                    CONV_CLOCK_TICK <= 1'b1;
                end else begin
                    // Still inside the period
                    period_cnt_r <= period_cnt_r + 8'h01;
                end
            end
        end
    end

endmodule

// ---- testbench/adc_sel_chk.sv ----
// Assertion checker for the converter input selection block
`include "adc_sel_defs.vh"
module adc_sel_chk (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Register bus
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Sample handshake and selection
    input wire logic SAMPLE_START,
    input wire logic SEQ_RESTART,
    input wire logic [4:0] POS_INPUT_SEL,
    input wire logic NEG_INPUT_IS_PIN_ONE,
    input wire logic SAMPLE_USES_SETTING_B,
    // Pin mode and conversion clock
    input wire logic [15:0] PIN_DIGITAL_MODE,
    input wire logic [15:0] PIN_ANALOG_SAMPLE_EN,
    input wire logic CONV_CLOCK_TICK
);
    timeunit 1ns;
    timeprecision 1ps;
    // Single domain, reset aborts every check
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // Restart pulse followed by one idle cycle
    sequence s_restart; SEQ_RESTART ##1 (!SAMPLE_START && !SEQ_RESTART); endsequence
    // Plain sample start
    sequence s_first; SAMPLE_START && !SEQ_RESTART; endsequence
    // Completed write to the low pin configuration
    sequence s_cfg_wr; PSEL && PENABLE && PREADY && PWRITE && PADDR == `OFS_PIN_CFG_LOW; endsequence
    // Mode copy may lag a cycle, so look two edges on
    AST_CFG_WRITE: assert property (s_cfg_wr |=> ##1 PIN_DIGITAL_MODE == $past(PWDATA[15:0], 2))
        else $error("pin mode does not follow config write");
    AST_ANALOG_INV: assert property (PIN_ANALOG_SAMPLE_EN == ~PIN_DIGITAL_MODE)
        else $error("analog enable not inverse of mode");
    AST_HOLD: assert property (!SAMPLE_START && !SEQ_RESTART |=> $stable(POS_INPUT_SEL)
        && $stable(NEG_INPUT_IS_PIN_ONE) && $stable(SAMPLE_USES_SETTING_B)) else $error("selection moved between samples");
    AST_RESTART_A: assert property (s_restart ##1 s_first |=> !SAMPLE_USES_SETTING_B)
        else $error("first sample after restart not setting A");
    AST_CODE_RANGE: assert property (POS_INPUT_SEL <= `CODE_FULL_BG)
        else $error("positive code outside implemented set");
    AST_TICK_ONE: assert property (CONV_CLOCK_TICK |=> !CONV_CLOCK_TICK)
        else $error("conversion tick longer than one cycle");
    AST_READY_ONE: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY)
        else $error("ready not a single cycle after setup");
    AST_SEL_ZERO: assert property (PREADY && !PWRITE && PADDR == `OFS_INPUT_MUX_SELECT
        |-> (PRDATA[15:0] & ~`MASK_INPUT_MUX_SELECT) == 16'h0000) else $error("select spare bits not zero");
    AST_HIGH_ZERO: assert property (PREADY && !PWRITE && PADDR == `OFS_PIN_CFG_HIGH
        |-> PRDATA[15:2] == 14'h0000) else $error("high config spare bits not zero");
endmodule

bind adc_input_select adc_sel_chk i_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SAMPLE_START(SAMPLE_START), .SEQ_RESTART(SEQ_RESTART), .POS_INPUT_SEL(POS_INPUT_SEL),
    .NEG_INPUT_IS_PIN_ONE(NEG_INPUT_IS_PIN_ONE), .SAMPLE_USES_SETTING_B(SAMPLE_USES_SETTING_B),
    .PIN_DIGITAL_MODE(PIN_DIGITAL_MODE), .PIN_ANALOG_SAMPLE_EN(PIN_ANALOG_SAMPLE_EN),
    .CONV_CLOCK_TICK(CONV_CLOCK_TICK));

// ---- testbench/sh_model.sv ----
// Behavioural sample-and-hold side that starts and restarts samples
module sh_model (
    // Clock
    input wire logic clk,
    // Sample handshake
    output logic start,
    output logic restart
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle until asked for a sample
    initial begin
        start = 1'b0;
        restart = 1'b0;
    end
    // One-cycle pulse, slow when dly is nonzero; returns mid-cycle so outputs are settled
    task pulse(input logic rs, input int dly);
        repeat (dly) @(posedge clk);
        @(posedge clk);
        restart <= rs;
        start <= !rs;
        @(posedge clk);
        restart <= 1'b0;
        start <= 1'b0;
        @(negedge clk);
    endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the converter input selection block
`include "adc_sel_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Register row: address, write value, expected read, expected error
    typedef struct packed {logic [11:0] a; logic [15:0] d; logic [15:0] q; logic e;} row_t;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic sample_start, seq_restart, neg_pin_one, uses_b, conv_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] pos_sel;
    logic [15:0] pin_digital, pin_analog;
    int miscompares = 0;
    int samples_checked = 0;
    int n;
    // Divider kept below the reserved range
    row_t rows[6] = '{'{12'h000, 16'hFFFF, 16'h9F9F, 1'b0}, '{12'h004, 16'hA5C3, 16'hA5C3, 1'b0},
        '{12'h008, 16'hFFFF, 16'h0003, 1'b0}, '{12'h00C, 16'h5A3C, 16'h5A3C, 1'b0},
        '{12'h010, 16'h033F, 16'h033F, 1'b0}, '{12'h01C, 16'hFFFF, 16'h0000, 1'b1}};
    logic [4:0] scan_exp[4] = '{5'h00, 5'h02, 5'h10, 5'h00};

    adc_input_select i_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SAMPLE_START(sample_start), .SEQ_RESTART(seq_restart), .POS_INPUT_SEL(pos_sel),
        .NEG_INPUT_IS_PIN_ONE(neg_pin_one), .SAMPLE_USES_SETTING_B(uses_b), .PIN_DIGITAL_MODE(pin_digital),
        .PIN_ANALOG_SAMPLE_EN(pin_analog), .CONV_CLOCK_TICK(conv_tick));
    sh_model i_sh (.clk(clk_sys), .start(sample_start), .restart(seq_restart));

    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task stop_test;
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One APB transfer, held until ready is seen high
    task apb(input logic [11:0] a, input logic w, input logic [15:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {16'h0000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 20) begin
            miscompares++;
            stop_test;
        end
        // Response taken at the edge that completes the access
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Current sample selection against expectation
    task chk_sel(input logic [4:0] p, input logic ng, input logic b);
        chk({25'h0000000, pos_sel, neg_pin_one, uses_b}, {25'h0000000, p, ng, b});
    endtask
    // All five control registers read zero
    task reset_regs;
        for (int i = 0; i < 5; i++) begin
            apb(12'(4 * i), 1'b0, 16'h0000);
            chk(rd, 32'h00000000);
        end
    endtask

    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Main sequence
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        reset_regs;
        foreach (rows[i]) begin
            apb(rows[i].a, 1'b1, rows[i].d);
            apb(rows[i].a, 1'b0, 16'h0000);
            chk(rd, {16'h0000, rows[i].q});
            chk({31'h00000000, err}, {31'h00000000, rows[i].e});
        end
        repeat (2) @(negedge clk_sys);
        chk({pin_digital, pin_analog}, 32'hA5C35A3C);
        // Divider 3 with alternate mode: tick every 8 clocks
        apb(`OFS_CONV_CTRL, 1'b1, 16'h0203);
        for (n = 0; conv_tick !== 1'b1 && n < 200; n++) @(negedge clk_sys);
        @(negedge clk_sys);
        for (n = 1; conv_tick !== 1'b1 && n < 40; n++) @(negedge clk_sys);
        chk(n, 32'h00000008);
        // Every implemented code on both settings, A first then B then A
        for (int c = 0; c < 18; c++) begin
            apb(`OFS_INPUT_MUX_SELECT, 1'b1, {1'b1, 2'b00, c[4:0], 3'b000, 5'(17 - c)});
            i_sh.pulse(1'b1, 0);
            i_sh.pulse(1'b0, c % 3);
            chk_sel(5'(17 - c), 1'b0, 1'b0);
            i_sh.pulse(1'b0, 0);
            chk_sel(c[4:0], 1'b1, 1'b1);
            i_sh.pulse(1'b0, 0);
            chk_sel(5'(17 - c), 1'b0, 1'b0);
        end
        // Scan pins 0 and 2 plus half bandgap, bandgap excluded
        apb(`OFS_SCAN_MASK, 1'b1, 16'h0005);
        apb(`OFS_PIN_CFG_HIGH, 1'b1, 16'h0002);
        apb(`OFS_CONV_CTRL, 1'b1, 16'h0100);
        i_sh.pulse(1'b1, 0);
        foreach (scan_exp[i]) begin
            i_sh.pulse(1'b0, 0);
            chk_sel(scan_exp[i], 1'b0, 1'b0);
        end
        // Swap the internal channels: bandgap in, half bandgap out
        apb(`OFS_PIN_CFG_HIGH, 1'b1, 16'h0001);
        i_sh.pulse(1'b0, 1);
        chk_sel(5'h02, 1'b0, 1'b0);
        i_sh.pulse(1'b0, 0);
        chk_sel(5'h11, 1'b0, 1'b0);
        // Status word mirrors the live selection: setting A, reference, bandgap
        apb(`OFS_SAMPLE_STATUS, 1'b0, 16'h0000);
        chk(rd, 32'h00000011);
        // Second reset in mid-run
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        // Outputs already cleared while reset is held, every pin analog
        chk_sel(5'h00, 1'b0, 1'b0);
        chk({pin_digital, pin_analog}, 32'h0000FFFF);
        chk({31'h00000000, conv_tick}, 32'h00000000);
        rst_n <= 1'b1;
        reset_regs;
        stop_test;
    end
endmodule
